// ==== rtl/prs_cfg.svh ====
// constants for the rank shadow-set selector
// assumes inclusion by bare name from rtl/ files only
`ifndef PRS_CFG_SVH
`define PRS_CFG_SVH

// ----------------------------------------------------------------
// capacity limits and defaults
// ----------------------------------------------------------------
`define PRS_MAX_SETS     4
`define PRS_MAX_RATE     4
`define PRS_DEF_RATE     4
`define PRS_DEF_SET_W    32

// ----------------------------------------------------------------
// reset values and the aligned first slot
// ----------------------------------------------------------------
`define PRS_RANK_RST     2'h0
`define PRS_SLOT_RST     2'h0
`define PRS_SET_RST      32'h0000_0000
`define PRS_FIRST_SLOT   2'h0

`endif

// ==== rtl/prs_pkg.sv ====
// types shared by the rank shadow-set selector
// assumes prs_cfg.svh holds the numeric limits
package prs_pkg;

	// ----------------------------------------------------------------
	// index types
	// ----------------------------------------------------------------
	typedef logic [1:0] rank_idx_t;  // logical rank, up to four sets
	typedef logic [1:0] slot_idx_t;  // memory slot within one phy clock

endpackage

// ==== rtl/prs_shadow_bank.sv ====
// per-rank storage of calibrated timing settings
// assumes the sequencer writes one rank's set at a time on the phy clock
`timescale 1ns/1ps
`include "prs_cfg.svh"

module prs_shadow_bank
	import prs_pkg::*;
#(
	parameter int NR    = `PRS_MAX_SETS,
	parameter int SET_W = `PRS_DEF_SET_W
) (
	input  wire logic                clk_i,
	input  wire logic                rst_b_i,
	input  wire logic                we_i,
	input  wire rank_idx_t           widx_i,
	input  wire logic [SET_W-1:0]    wdata_i,
	output logic      [NR*SET_W-1:0] sets_o
);

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic [SET_W-1:0] set_r   [NR];
	logic [SET_W-1:0] set_nxt [NR];

	// each rank owns its own set; a write touches only that one
	always_comb begin
		for (int i = 0; i < NR; i++) begin
			set_nxt[i] = set_r[i];
		end
		if (we_i && (int'(widx_i) < NR)) begin
			set_nxt[widx_i] = wdata_i;
		end
	end

	// register the sets
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			for (int i = 0; i < NR; i++) begin
				set_r[i] <= SET_W'(`PRS_SET_RST);
			end
		end else begin
			for (int i = 0; i < NR; i++) begin
				set_r[i] <= set_nxt[i];
			end
		end
	end

	// flatten, rank 0 in the low word
	always_comb begin
		for (int i = 0; i < NR; i++) begin
			sets_o[i*SET_W +: SET_W] = set_r[i];
		end
	end

endmodule

// ==== rtl/phy_rank_shadow_select.sv ====
// rank shadow-set selector on the controller side of the memory phy
// assumes controller inputs are on CLK_I; sequencer loads sets before use
//
// Function
// RULE_01 - keep a separately calibrated setting set per rank, filled independently
// RULE_02 - on a rank change, present the new rank's set for that transfer
// RULE_03 - pick active sets from the write-rank and read-rank selects
// RULE_04 - controller drives write rank exactly like strobe burst enable; the bench model toggles released write rank lanes outside the burst window
// RULE_05 - controller presents read rank with read data enable
// RULE_06 - controller holds read rank until a read to another rank
// RULE_07 - rank selects are one-hot per slot word
// RULE_08 - select buses are slot ordered, earliest slot in lowest word
// RULE_09 - reads to different ranks are at least 3 full-rate cycles apart
// RULE_10 - writes to different ranks are at least 4 full-rate cycles apart
// RULE_11 - at most four independent shadow sets
// RULE_12 - more physical ranks only when mapped onto four logical ranks
// RULE_13 - command slot k of a phy clock goes to memory slot k
// RULE_14 - a write in slot 0 is aligned, any later slot unaligned
// RULE_15 - controller keeps command-to-data slot distance constant
// RULE_16 - controller shifts write data for unaligned writes
// RULE_17 - controller delays write signals by the calibrated write latency
// RULE_18 - controller raises strobe burst early for the preamble; the bench model raises it with the write window, in the command clock
// RULE_19 - keep the last read set while the read select is unchanged
`timescale 1ns/1ps
`include "prs_cfg.svh"

module phy_rank_shadow_select
	import prs_pkg::*;
#(
	parameter int RATE  = `PRS_DEF_RATE,
	parameter int NR    = `PRS_MAX_SETS,
	parameter int SET_W = `PRS_DEF_SET_W
) (
	input  wire logic                  CLK_I,
	input  wire logic                  RST_B_I,
	input  wire logic                  CAL_WE_I,
	input  wire rank_idx_t             CAL_RANK_I,
	input  wire logic [SET_W-1:0]      CAL_DATA_I,
	input  wire logic [RATE*NR-1:0]    WRANK_I,
	input  wire logic [RATE-1:0]       DQS_BURST_I,
	input  wire logic [RATE*NR-1:0]    RRANK_I,
	input  wire logic [RATE-1:0]       RDATA_EN_I,
	input  wire logic [RATE-1:0]       WR_CMD_I,
	output logic      [RATE*SET_W-1:0] WR_SET_O,
	output logic      [RATE*SET_W-1:0] RD_SET_O,
	output rank_idx_t                  WR_RANK_O,
	output rank_idx_t                  RD_RANK_O,
	output logic                       RANK_ERR_O,
	output slot_idx_t                  WR_SLOT_O,
	output logic                       WR_UNALIGNED_O
);

	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	// only four sets exist; more physical ranks must share logical ones
	if (NR < 1 || NR > `PRS_MAX_SETS) begin : g_bad_nr  // see RULE_11 see RULE_12
		$error("rank count must be 1 to 4 logical ranks");
	end
	if (RATE != 1 && RATE != 2 && RATE != `PRS_MAX_RATE) begin : g_bad_rate
		$error("rate must be 1, 2 or 4 slots per phy clock");
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// a word names a rank only with exactly one bit set
	function automatic logic onehot_ok(input logic [NR-1:0] w);
		return (w != '0) && ((w & (w - NR'(1))) == '0);  // see RULE_07
	endfunction

	function automatic rank_idx_t onehot_idx(input logic [NR-1:0] w);
		rank_idx_t idx;
		idx = `PRS_RANK_RST;
		for (int i = 0; i < NR; i++) begin
			if (w[i]) begin
				idx = rank_idx_t'(i);
			end
		end
		return idx;
	endfunction

	// ----------------------------------------------------------------
	// shadow storage
	// ----------------------------------------------------------------
	logic [NR*SET_W-1:0] sets;

	prs_shadow_bank #(
		.NR    (NR),
		.SET_W (SET_W)
	) u_bank (
		.clk_i   (CLK_I),
		.rst_b_i (RST_B_I),
		.we_i    (CAL_WE_I),    // see RULE_01
		.widx_i  (CAL_RANK_I),
		.wdata_i (CAL_DATA_I),
		.sets_o  (sets)
	);

	// ----------------------------------------------------------------
	// rank selection per slot
	// ----------------------------------------------------------------
	rank_idx_t                  wr_rank_r;
	rank_idx_t                  wr_rank_nxt;
	rank_idx_t                  rd_rank_r;
	rank_idx_t                  rd_rank_nxt;
	rank_idx_t                  rd_idx [RATE];
	logic                       err_nxt;
	logic                       err_r;
	logic [RATE*SET_W-1:0]      wr_set_nxt;
	logic [RATE*SET_W-1:0]      rd_set_nxt;
	logic [RATE*SET_W-1:0]      wr_set_r;
	logic [RATE*SET_W-1:0]      rd_set_r;

	// walk slots earliest first, carrying the rank across slots and clocks
	always_comb begin
		rank_idx_t       wcur;
		rank_idx_t       rcur;
		logic [NR-1:0]   ww;
		logic [NR-1:0]   rw;
		wcur    = wr_rank_r;
		rcur    = rd_rank_r;
		ww      = '0;
		rw      = '0;
		err_nxt = 1'b0;
		for (int s = 0; s < RATE; s++) begin
			ww = WRANK_I[s*NR +: NR];  // see RULE_08
			rw = RRANK_I[s*NR +: NR];
			// write rank counts only under strobe burst enable
			if (DQS_BURST_I[s]) begin
				if (onehot_ok(ww)) begin
					wcur = onehot_idx(ww);  // see RULE_03 see RULE_02
				end else begin
					err_nxt = 1'b1;  // see RULE_07
				end
			end
			// read rank is sampled with read enable, held otherwise
			if (RDATA_EN_I[s]) begin
				if (onehot_ok(rw)) begin
					rcur = onehot_idx(rw);  // see RULE_03 see RULE_02
				end else begin
					err_nxt = 1'b1;  // see RULE_07
				end
			end
			rd_idx[s] = rcur;  // see RULE_19
			wr_set_nxt[s*SET_W +: SET_W] = sets[int'(wcur)*SET_W +: SET_W];
			rd_set_nxt[s*SET_W +: SET_W] = sets[int'(rcur)*SET_W +: SET_W];
		end
		wr_rank_nxt = wcur;
		rd_rank_nxt = rcur;
	end

	// register selection state and the sets presented to the lanes
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			wr_rank_r <= `PRS_RANK_RST;
			rd_rank_r <= `PRS_RANK_RST;
			err_r     <= 1'b0;
			wr_set_r  <= '0;
			rd_set_r  <= '0;
		end else begin
			wr_rank_r <= wr_rank_nxt;
			rd_rank_r <= rd_rank_nxt;
			err_r     <= err_nxt;
			wr_set_r  <= wr_set_nxt;
			rd_set_r  <= rd_set_nxt;
		end
	end

	// ----------------------------------------------------------------
	// write command slot alignment
	// ----------------------------------------------------------------
	slot_idx_t slot_nxt;
	slot_idx_t slot_r;
	logic      unal_nxt;
	logic      unal_r;

	// first write slot of this clock; slot k maps to memory slot k
	always_comb begin
		slot_nxt = slot_r;
		unal_nxt = 1'b0;
		for (int s = RATE - 1; s >= 0; s--) begin
			if (WR_CMD_I[s]) begin
				slot_nxt = slot_idx_t'(s);  // see RULE_13
			end
		end
		if (WR_CMD_I != '0) begin
			unal_nxt = (slot_nxt != `PRS_FIRST_SLOT);  // see RULE_14
		end
	end

	// register slot information
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			slot_r <= `PRS_SLOT_RST;
			unal_r <= 1'b0;
		end else begin
			slot_r <= slot_nxt;
			unal_r <= unal_nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign WR_SET_O       = wr_set_r;
	assign RD_SET_O       = rd_set_r;
	assign WR_RANK_O      = wr_rank_r;
	assign RD_RANK_O      = rd_rank_r;
	assign RANK_ERR_O     = err_r;
	assign WR_SLOT_O      = slot_r;
	assign WR_UNALIGNED_O = unal_r;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RST_B_I);

	// helpers: last-slot rank words and the set chosen for slot 0
	logic [NR-1:0]    w_last;
	logic [NR-1:0]    r_last;
	logic [SET_W-1:0] rd0_sel;
	assign w_last   = WRANK_I[(RATE-1)*NR +: NR];
	assign r_last   = RRANK_I[(RATE-1)*NR +: NR];
	assign rd0_sel  = sets[int'(rd_idx[0])*SET_W +: SET_W];

	a_cal_store_set: assert property ( // see RULE_01
		CAL_WE_I && (int'(CAL_RANK_I) < NR) |=>
		($past(CAL_DATA_I) == sets[int'($past(CAL_RANK_I))*SET_W +: SET_W]))
		else $error("calibration word not stored in its rank set");

	a_wr_rank_take: assert property ( // see RULE_03
		DQS_BURST_I[RATE-1] && onehot_ok(w_last) |=> (wr_rank_r == onehot_idx($past(w_last))))
		else $error("write rank not taken from last burst slot");

	a_rd_rank_take: assert property ( // see RULE_02
		RDATA_EN_I[RATE-1] && onehot_ok(r_last) |=> (RD_RANK_O == onehot_idx($past(r_last))))
		else $error("read rank not taken from last read slot");

	a_rd_rank_hold: assert property ( // see RULE_19
		(RDATA_EN_I == '0) [*2] |=> $stable(RD_RANK_O) && (RD_RANK_O == $past(RD_RANK_O, 2)))
		else $error("read rank moved without a read");

	a_rd_set_mux: assert property ( // see RULE_02
		!CAL_WE_I |=> (RD_SET_O[SET_W-1:0] == $past(rd0_sel)))
		else $error("read set for slot 0 does not match selected rank");

	a_onehot_err: assert property ( // see RULE_07
		DQS_BURST_I[0] && !onehot_ok(WRANK_I[NR-1:0]) |=> RANK_ERR_O)
		else $error("bad write rank word not flagged");

	a_slot_zero_aligned: assert property ( // see RULE_13
		WR_CMD_I[0] |=> (WR_SLOT_O == `PRS_FIRST_SLOT) && !WR_UNALIGNED_O)
		else $error("slot 0 write not reported as aligned");

	a_unaligned_flag: assert property ( // see RULE_14
		(WR_CMD_I != '0) && !WR_CMD_I[0] |=> WR_UNALIGNED_O ##1 (WR_UNALIGNED_O == ($past(WR_CMD_I) != '0 &&
		!$past(WR_CMD_I[0]))))
		else $error("later-slot write not reported as unaligned");

	a_rank_in_range: assert property ( // see RULE_11
		(int'(WR_RANK_O) < NR) && (int'(RD_RANK_O) < NR))
		else $error("selected rank beyond the shadow sets");

	c_rank_switch: cover property (RDATA_EN_I[0] ##[1:4] RDATA_EN_I[0] && $changed(RD_RANK_O));
	c_unaligned: cover property (WR_CMD_I != '0 && !WR_CMD_I[0]);
	c_cal_then_write: cover property (CAL_WE_I ##[1:8] DQS_BURST_I[0]);

endmodule

// ==== bench/prs_ctrl_model.sv ====
// memory controller model driving the selector's controller-side inputs
// assumes one request pulse at a time from the bench, spaced by the bench
`timescale 1ns/1ps

module prs_ctrl_model
	import prs_pkg::*;
#(
	parameter int RATE = 4,
	parameter int NR   = 4
) (
	input  wire logic               clk_i,
	input  wire logic               rst_b_i,
	input  wire logic               wr_i,
	input  wire logic               rd_i,
	input  wire logic               bad_i,
	input  wire rank_idx_t          rank_i,
	input  wire slot_idx_t          slot_i,
	output logic      [RATE*NR-1:0] wrank_o,
	output logic      [RATE-1:0]    dqs_burst_o,
	output logic      [RATE*NR-1:0] rrank_o,
	output logic      [RATE-1:0]    rdata_en_o,
	output logic      [RATE-1:0]    wr_cmd_o
);
	// ----------------------------------------------------------------
	// next-state of the controller outputs
	// ----------------------------------------------------------------
	logic [RATE*NR-1:0] wrank_r, wrank_nxt, rrank_r, rrank_nxt;
	logic [RATE-1:0]    burst_r, burst_nxt, en_r, en_nxt, cmd_r, cmd_nxt, mask;
	logic [NR-1:0]      word;

	// one command per clock, window from the command slot upward
	always_comb begin
		mask      = ~((RATE'(1) << slot_i) - RATE'(1));
		word      = bad_i ? NR'(3) : (NR'(1) << rank_i);
		burst_nxt = '0;
		en_nxt    = '0;
		cmd_nxt   = '0;
		wrank_nxt = ~wrank_r; // released lanes toggle; lanes below the slot of a write carry the inverted word
		rrank_nxt = rrank_r;
		for (int s = 0; s < RATE; s++) begin
			if (wr_i) begin
				cmd_nxt[s]             = (s == int'(slot_i));
				// write latency zero: burst and data window share the command clock
				burst_nxt[s]           = mask[s];
				wrank_nxt[s*NR +: NR]  = mask[s] ? word : ~word;
			end
			if (rd_i) begin
				en_nxt[s] = mask[s];
				if (mask[s]) begin
					rrank_nxt[s*NR +: NR] = word;
				end
			end
		end
	end

	// registers, cleared in reset
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wrank_r <= '0;
			rrank_r <= '0;
			burst_r <= '0;
			en_r    <= '0;
			cmd_r   <= '0;
		end else begin
			wrank_r <= wrank_nxt;
			rrank_r <= rrank_nxt;
			burst_r <= burst_nxt;
			en_r    <= en_nxt;
			cmd_r   <= cmd_nxt;
		end
	end

	assign wrank_o     = wrank_r;
	assign rrank_o     = rrank_r;
	assign dqs_burst_o = burst_r;
	assign rdata_en_o  = en_r;
	assign wr_cmd_o    = cmd_r;
endmodule

// ==== bench/phy_rank_shadow_select_tb.sv ====
// self-checking bench for the rank shadow-set selector
// assumes default RATE, NR and SET_W of the design
`timescale 1ns/1ps

module phy_rank_shadow_select_tb;
	import prs_pkg::*;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic         clk = 0, rst_b = 0, cal_we = 0, wr = 0, rd = 0, bad = 0;
	rank_idx_t    cal_rank = '0, rank = '0, wr_rank, rd_rank;
	slot_idx_t    slot = '0, wr_slot;
	logic [31:0]  cal_data = 32'h0000_0000;
	logic [15:0]  wrank, rrank;
	logic [3:0]   burst, en, cmd;
	logic [127:0] wr_set, rd_set;
	logic         rank_err, unal;
	int           fails = 0, checked = 0;

	always #5 clk = ~clk;

	prs_ctrl_model i_ctrl (.clk_i(clk), .rst_b_i(rst_b), .wr_i(wr), .rd_i(rd), .bad_i(bad), .rank_i(rank),
		.slot_i(slot), .wrank_o(wrank), .dqs_burst_o(burst), .rrank_o(rrank), .rdata_en_o(en), .wr_cmd_o(cmd));

	phy_rank_shadow_select i_dut (.CLK_I(clk), .RST_B_I(rst_b), .CAL_WE_I(cal_we), .CAL_RANK_I(cal_rank),
		.CAL_DATA_I(cal_data), .WRANK_I(wrank), .DQS_BURST_I(burst), .RRANK_I(rrank), .RDATA_EN_I(en),
		.WR_CMD_I(cmd), .WR_SET_O(wr_set), .RD_SET_O(rd_set), .WR_RANK_O(wr_rank), .RD_RANK_O(rd_rank),
		.RANK_ERR_O(rank_err), .WR_SLOT_O(wr_slot), .WR_UNALIGNED_O(unal));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] sv(input int r);
		return {8{4'(r) + 4'h5}};
	endfunction

	// lower slots keep the old rank's set, the rest the new one
	function automatic logic [127:0] eb(input int o, input int n, input int s);
		logic [127:0] e;
		for (int i = 0; i < 4; i++) e[i*32 +: 32] = (i < s) ? sv(o) : sv(n);
		return e;
	endfunction

	task automatic cmp_bus(input logic [127:0] got, input logic [127:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t %s", $time, what);
		end
	endtask

	task automatic cmp_fld(input logic [3:0] got, input logic [3:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t %s", $time, what);
		end
	endtask

	// one request, then two clocks of quiet: 12 full-rate slots between commands
	task automatic issue(input logic w, input logic r, input logic b, input int rk, input int sl);
		@(posedge clk);
		wr <= w;
		rd <= r;
		bad <= b;
		rank <= 2'(rk);
		slot <= 2'(sl);
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b0;
		bad <= 1'b0;
		@(posedge clk);
		#1;
	endtask

	task automatic end_of_test;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_cal;
		#1;
		cmp_bus(wr_set, '0, "reset write sets");
		cmp_bus(rd_set, '0, "reset read sets");
		for (int r = 0; r < 4; r++) begin
			@(posedge clk);
			cal_we <= 1'b1;
			cal_rank <= 2'(r);
			cal_data <= sv(r);
		end
		@(posedge clk);
		cal_we <= 1'b0;
		$display("t_cal done");
	endtask

	task automatic t_wr_ranks;
		for (int r = 3; r >= 0; r--) begin
			issue(1, 0, 0, r, 0);
			cmp_fld(wr_rank, 4'(r), "write rank");
			cmp_bus(wr_set, eb(r, r, 0), "write set per rank");
			cmp_fld(unal, 4'h0, "aligned write flagged");
		end
		$display("t_wr_ranks done");
	endtask

	task automatic t_unaligned;
		for (int s = 1; s < 4; s++) begin
			issue(1, 0, 0, s, s);
			cmp_bus(wr_set, eb(s - 1, s, s), "slot ordered write set");
			cmp_fld(wr_slot, 4'(s), "write slot");
			cmp_fld(unal, 4'h1, "unaligned flag");
			@(posedge clk);
			#1;
			cmp_fld(unal, 4'h0, "unaligned flag length");
		end
		$display("t_unaligned done");
	endtask

	task automatic t_read;
		issue(0, 1, 0, 3, 1);
		cmp_fld(rd_rank, 4'h3, "read rank");
		cmp_bus(rd_set, eb(0, 3, 1), "read set slots");
		repeat (3) @(posedge clk);
		#1;
		cmp_bus(rd_set, eb(3, 3, 0), "read set held");
		issue(0, 1, 0, 1, 0);
		cmp_bus(rd_set, eb(3, 1, 0), "read set switched");
		$display("t_read done");
	endtask

	task automatic t_err;
		issue(1, 0, 1, 0, 0);
		cmp_fld(rank_err, 4'h1, "bad word error");
		cmp_fld(wr_rank, 4'h3, "bad word rank kept");
		@(posedge clk);
		#1;
		cmp_fld(rank_err, 4'h0, "error pulse length");
		issue(0, 1, 1, 0, 0);
		cmp_fld(rank_err, 4'h1, "bad read word error");
		cmp_fld(rd_rank, 4'h1, "bad read word rank kept");
		$display("t_err done");
	endtask

	// ----------------------------------------------------------------
	// main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		t_cal();
		t_wr_ranks();
		t_unaligned();
		t_read();
		t_err();
		end_of_test();
	end

	initial begin
		repeat (2000) @(posedge clk);
		fails++;
		end_of_test();
	end
endmodule
